//--- hw/rtc_pkg.sv
// constants and codes shared by the real-time counter and periodic timer
// *****************************************************************
// Operation
// - debug halt stops counter and timer unless enabled
// - sign zero makes prescaler count slower
// - sign one counts faster; needs divide-by-two
// - insert error clocks per million RTC cycles
// - two-bit field selects RTC clock source
// - 16-bit values as low, then high byte
// - count, period writes apply after two ticks
// - period code sets timer interval, doubling
// - periodic timer runs only while enabled
// - timer busy while control write synchronises
// - timer interrupt forwarded only when enabled
// - timer flag set per period, one clears
// - compare and overflow flags set, one clears
// - prescaler power-of-two divide; correction needs enable
// *****************************************************************
package rtc_pkg;

	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h01;
	localparam logic [7:0] OFS_INT_EN    = 8'h02;
	localparam logic [7:0] OFS_INT_FLAG  = 8'h03;
	localparam logic [7:0] OFS_DBG       = 8'h05;
	localparam logic [7:0] OFS_CRYSTAL_ERROR_CALIBRATION     = 8'h06;
	localparam logic [7:0] OFS_SRC       = 8'h07;
	localparam logic [7:0] OFS_CNT       = 8'h08;
	localparam logic [7:0] OFS_PER       = 8'h0a;
	localparam logic [7:0] OFS_CMP       = 8'h0c;
	localparam logic [7:0] OFS_PIT_CTRL  = 8'h10;
	localparam logic [7:0] OFS_PIT_STAT  = 8'h11;
	localparam logic [7:0] OFS_PIT_IEN   = 8'h12;
	localparam logic [7:0] OFS_PIT_FLAG  = 8'h13;
	localparam logic [7:0] OFS_PIT_DBG   = 8'h15;
	localparam logic [7:0] OFS_HIGH_BYTE = 8'h01;

	// field positions
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_CORR_BIT  = 2;
	localparam int CTRL_DIV_LSB   = 3;
	localparam int CRYSTAL_ERROR_CALIBRATION_SIGN_BIT = 7;
	localparam int PIT_CODE_LSB   = 3;
	localparam int STAT_CNT_BIT   = 1;
	localparam int STAT_PER_BIT   = 2;
	localparam int FLAG_OVF_BIT   = 0;
	localparam int FLAG_CMP_BIT   = 1;

	// writable bits and values after reset
	localparam logic [7:0]  CTRL_MASK     = 8'h7d;
	localparam logic [7:0]  PIT_CTRL_MASK = 8'h79;
	localparam logic [7:0]  REG8_RESET    = 8'h00;
	localparam logic [15:0] CNT_RESET     = 16'h0000;
	localparam logic [15:0] PER_RESET     = 16'hffff;
	localparam logic [15:0] CMP_RESET     = 16'h0000;

	// cycle counts, in RTC ticks and internal oscillator edges
	localparam logic [1:0]  SYNC_LAST  = 2'h1;       // two ticks of latency
	localparam logic [19:0] PPM_LAST   = 20'hf423f;  // 1000000 - 1
	localparam logic [3:0]  KHZ_TOGGLE = 4'hf;       // 32 edges per period

	// periodic timer codes without an interval
	localparam logic [3:0] PIT_CODE_OFF  = 4'h0;
	localparam logic [3:0] PIT_CODE_RSVD = 4'hf;

	// RTC clock source codes
	typedef enum logic [1:0] {
		SRC_INTERNAL = 2'h0,
		SRC_KHZ_TAP  = 2'h1,
		SRC_CRYSTAL  = 2'h2,
		SRC_EXTERNAL = 2'h3
	} src_sel_t;

endpackage

//--- hw/rtc_periodic_timer.sv
// real-time counter with prescaler, correction and periodic timer
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module rtc_periodic_timer
	import rtc_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// RTC clock sources, asynchronous
	input  wire logic       internal_slow_oscillator,
	input  wire logic       crystal_input_pin,
	input  wire logic       external_clock_pin,
	// processor halted by debugger
	input  wire logic       debug_halted,
	// interrupt request, level
	output logic            irq
);

	// *****************************************************************
	// state
	// *****************************************************************

	// every flip-flop of the block
	typedef struct packed {
		logic [2:0]  src_s1;      // first sync stage
		logic [2:0]  src_s2;      // second sync stage
		logic        osc_prev;    // internal oscillator edge memory
		logic [3:0]  khz_div;     // divider for the kilohertz tap
		logic        khz_lvl;     // kilohertz tap level
		logic        sel_prev;    // selected source edge memory
		logic [7:0]  ctrl;        // enable, correction, prescaler
		logic [1:0]  int_en;      // compare and overflow enables
		logic [1:0]  flags;       // compare and overflow flags
		logic        dbg_run;     // counter runs while halted
		logic [7:0]  crystal_error_calibration;       // sign and error magnitude
		logic [1:0]  src;         // clock source select
		logic [15:0] cnt;         // live count
		logic [15:0] cnt_shadow;  // count waiting for sync
		logic [15:0] per;         // live period
		logic [15:0] per_shadow;  // period waiting for sync
		logic [15:0] cmp;         // compare value
		logic        cnt_busy;    // count sync pending
		logic        per_busy;    // period sync pending
		logic        pit_busy;    // timer control sync pending
		logic [1:0]  cnt_sync;    // ticks seen by count sync
		logic [1:0]  per_sync;    // ticks seen by period sync
		logic [1:0]  pit_sync;    // ticks seen by timer sync
		logic [7:0]  pit_ctrl;    // timer control as written
		logic [7:0]  pit_live;    // timer control in effect
		logic        pit_ien;     // timer interrupt enable
		logic        pit_flag;    // timer interrupt flag
		logic        pit_dbg;     // timer runs while halted
		logic [14:0] presc;       // prescaler
		logic [14:0] pit_cnt;     // timer tick counter
		logic [19:0] ppm_cnt;     // million-tick interval
		logic [6:0]  corr_left;   // corrections left this interval
		logic [7:0]  rdata;       // read answer
	} state_t;

	state_t st_reg;   // registered state
	state_t st_next;  // next state

	// *****************************************************************
	// decode helpers
	// *****************************************************************

	// one byte of a 16-bit value
	function automatic logic [7:0] byte_of(input logic [15:0] v,
		input logic hi);
		byte_of = hi ? v[15:8] : v[7:0];
	endfunction

	// merge a written byte into a 16-bit value
	function automatic logic [15:0] put_byte(input logic [15:0] v,
		input logic hi, input logic [7:0] b);
		put_byte = hi ? {b, v[7:0]} : {v[15:8], b};
	endfunction

	// low-ones mask for prescaler divide code
	function automatic logic [15:0] div_mask(input logic [3:0] d);
		div_mask = (16'h0001 << d) - 16'h0001;
	endfunction

	// low-ones mask for timer period code; code 1 gives four ticks
	function automatic logic [14:0] pit_mask(input logic [3:0] c);
		logic [15:0] m;
		m = (16'h0002 << c) - 16'h0001;
		pit_mask = m[14:0];
	endfunction

	// *****************************************************************
	// RTC tick from the selected source
	// *****************************************************************

	logic        osc_rise;  // internal oscillator rising edge
	logic        sel_lvl;   // level of the selected source
	logic        tick;      // one RTC clock cycle
	logic        cnt_run;   // counter advances
	logic        pit_run;   // timer advances
	logic [3:0]  div_code;  // prescaler code
	logic [3:0]  pit_code;  // timer period code
	logic        corr_act;  // a correction is due this tick
	logic        corr_neg;  // correction makes prescaler faster
	logic [1:0]  inc;       // prescaler step
	logic [15:0] dmask;     // prescaler mask
	logic [15:0] presc_sum; // prescaler plus step
	logic        cnt_evt;   // prescaler period ends
	logic        pit_evt;   // timer period ends
	logic        hi_sel;    // access to the high byte
	logic [7:0]  base;      // address with high-byte bit cleared

	// only second-stage copies are looked at
	assign osc_rise = st_reg.src_s2[0] & ~st_reg.osc_prev;

	// source multiplexer; a switch may add one stray tick
	always_comb
	begin
		case (src_sel_t'(st_reg.src))
			SRC_INTERNAL: sel_lvl = st_reg.src_s2[0];
			SRC_KHZ_TAP:  sel_lvl = st_reg.khz_lvl;
			SRC_CRYSTAL:  sel_lvl = st_reg.src_s2[1];
			SRC_EXTERNAL: sel_lvl = st_reg.src_s2[2];
			default:      sel_lvl = 1'b0;
		endcase
	end

	assign tick = sel_lvl & ~st_reg.sel_prev;

	// halted processor freezes unless run bit set
	assign cnt_run = st_reg.ctrl[CTRL_EN_BIT]
		& ~(debug_halted & ~st_reg.dbg_run);
	assign pit_run = st_reg.pit_live[0]
		& ~(debug_halted & ~st_reg.pit_dbg);

	// *****************************************************************
	// prescaler, correction and period events
	// *****************************************************************

	assign div_code = st_reg.ctrl[CTRL_DIV_LSB +: 4];
	assign pit_code = st_reg.pit_live[PIT_CODE_LSB +: 4];
	assign corr_act = st_reg.ctrl[CTRL_CORR_BIT]
		& (st_reg.corr_left != 7'h00);
	assign corr_neg = st_reg.crystal_error_calibration[CRYSTAL_ERROR_CALIBRATION_SIGN_BIT];

	// skip a step to slow down, double a step to speed up
	always_comb
	begin
		if (!corr_act)
			inc = 2'h1;
		else if (corr_neg)
			inc = 2'h2;
		else
			inc = 2'h0;
	end

	assign dmask     = div_mask(div_code);
	assign presc_sum = {1'b0, st_reg.presc} + {14'h0000, inc};
	assign cnt_evt   = tick & cnt_run
		& ((({1'b0, st_reg.presc} & dmask) + {14'h0000, inc}) > dmask);

	// off and reserved codes never fire
	assign pit_evt = tick & pit_run
		& (pit_code != PIT_CODE_OFF) & (pit_code != PIT_CODE_RSVD)
		& ((st_reg.pit_cnt & pit_mask(pit_code))
		== pit_mask(pit_code));

	assign hi_sel = addr[0];
	assign base   = addr & ~OFS_HIGH_BYTE;

	// *****************************************************************
	// next-state logic
	// *****************************************************************

	// one pass over sources, counter, timer and register port
	always_comb
	begin
		logic [1:0]  fl_set;
		logic [1:0]  fl_clr;
		logic        pit_set;
		logic        pit_clr;
		logic [15:0] nxt_cnt;
		fl_set  = 2'h0;
		fl_clr  = 2'h0;
		pit_set = 1'b0;
		pit_clr = 1'b0;
		nxt_cnt = st_reg.cnt;
		st_next = st_reg;
		st_next.rdata = 8'h00;

		// two-stage synchronisers and edge memories
		st_next.src_s1 = {external_clock_pin, crystal_input_pin,
			internal_slow_oscillator};
		st_next.src_s2   = st_reg.src_s1;
		st_next.osc_prev = st_reg.src_s2[0];
		st_next.sel_prev = sel_lvl;

		// kilohertz tap: oscillator divided by 32
		if (osc_rise)
		begin
			st_next.khz_div = st_reg.khz_div + 4'h1;
			if (st_reg.khz_div == KHZ_TOGGLE)
				st_next.khz_lvl = ~st_reg.khz_lvl;
		end

		// pending writes land on the second tick after the write
		if (tick)
		begin
			if (st_reg.cnt_busy)
			begin
				st_next.cnt_sync = st_reg.cnt_sync + 2'h1;
				if (st_reg.cnt_sync == SYNC_LAST)
					st_next.cnt_busy = 1'b0;
			end
			if (st_reg.per_busy)
			begin
				st_next.per_sync = st_reg.per_sync + 2'h1;
				if (st_reg.per_sync == SYNC_LAST)
				begin
					st_next.per      = st_reg.per_shadow;
					st_next.per_busy = 1'b0;
				end
			end
			if (st_reg.pit_busy)
			begin
				st_next.pit_sync = st_reg.pit_sync + 2'h1;
				if (st_reg.pit_sync == SYNC_LAST)
				begin
					st_next.pit_live = st_reg.pit_ctrl;
					st_next.pit_cnt  = 15'h0000;
					st_next.pit_busy = 1'b0;
				end
			end
		end

		// prescaler and correction interval
		if (tick && cnt_run)
		begin
			st_next.presc = presc_sum[14:0];
			if (corr_act)
				st_next.corr_left = st_reg.corr_left - 7'h01;
			if (st_reg.ppm_cnt == PPM_LAST)
			begin
				st_next.ppm_cnt   = 20'h00000;
				st_next.corr_left = st_reg.crystal_error_calibration[6:0];
			end
			else
				st_next.ppm_cnt = st_reg.ppm_cnt + 20'h00001;
		end

		// count with wrap at period and compare match
		if (cnt_evt)
		begin
			if (st_reg.cnt == st_reg.per)
			begin
				nxt_cnt = 16'h0000;
				fl_set[FLAG_OVF_BIT] = 1'b1;
			end
			else
				nxt_cnt = st_reg.cnt + 16'h0001;
			if (nxt_cnt == st_reg.cmp)
				fl_set[FLAG_CMP_BIT] = 1'b1;
		end
		// a synchronised count write wins over counting
		if (tick && st_reg.cnt_busy && st_reg.cnt_sync == SYNC_LAST)
			nxt_cnt = st_reg.cnt_shadow;
		st_next.cnt = nxt_cnt;

		// periodic timer; a landing control write restarts the count
		if (tick && pit_run
			&& !(st_reg.pit_busy && st_reg.pit_sync == SYNC_LAST))
			st_next.pit_cnt = st_reg.pit_cnt + 15'h0001;
		pit_set = pit_evt;

		// register writes
		if (wr)
		begin
			case (base)
				OFS_CTRL:
					if (!hi_sel)
						st_next.ctrl = wdata & CTRL_MASK;
				// flags sit one byte above the enables, on one base
				OFS_INT_EN:
					if (!hi_sel)
						st_next.int_en = wdata[1:0];
					else
						fl_clr = wdata[1:0];
				// odd offset: base has the high-byte bit cleared
				OFS_DBG & ~OFS_HIGH_BYTE:
					if (hi_sel)
						st_next.dbg_run = wdata[0];
				OFS_CRYSTAL_ERROR_CALIBRATION:
					if (!hi_sel)
						st_next.crystal_error_calibration = wdata;
					else
						st_next.src = wdata[1:0];
				OFS_CNT:
				begin
					st_next.cnt_shadow = put_byte(st_reg.cnt_busy ?
						st_reg.cnt_shadow : st_reg.cnt, hi_sel, wdata);
					st_next.cnt_busy = 1'b1;
					st_next.cnt_sync = 2'h0;
				end
				OFS_PER:
				begin
					st_next.per_shadow = put_byte(st_reg.per_busy ?
						st_reg.per_shadow : st_reg.per, hi_sel, wdata);
					st_next.per_busy = 1'b1;
					st_next.per_sync = 2'h0;
				end
				OFS_CMP:
					st_next.cmp = put_byte(st_reg.cmp, hi_sel, wdata);
				OFS_PIT_CTRL:
					if (!hi_sel)
					begin
						st_next.pit_ctrl = wdata & PIT_CTRL_MASK;
						st_next.pit_busy = 1'b1;
						st_next.pit_sync = 2'h0;
					end
				OFS_PIT_IEN:
					if (!hi_sel)
						st_next.pit_ien = wdata[0];
					else
						pit_clr = wdata[0];
				OFS_PIT_DBG & ~OFS_HIGH_BYTE:
					if (hi_sel)
						st_next.pit_dbg = wdata[0];
				default:
					st_next.rdata = 8'h00;  // unmapped write ignored
			endcase
		end

		// sticky flags: a set in the clearing cycle survives
		st_next.flags    = (st_reg.flags & ~fl_clr) | fl_set;
		st_next.pit_flag = (st_reg.pit_flag & ~pit_clr) | pit_set;

		// read answer, valid in the next cycle only
		if (rd)
		begin
			case (base)
				OFS_CTRL:
					st_next.rdata = hi_sel ? {5'h00, st_reg.per_busy,
						st_reg.cnt_busy, 1'b0} : st_reg.ctrl;
				OFS_INT_EN:
					st_next.rdata = hi_sel ? {6'h00, st_reg.flags}
						: {6'h00, st_reg.int_en};
				OFS_DBG & ~OFS_HIGH_BYTE:
					st_next.rdata = hi_sel ? {7'h00, st_reg.dbg_run}
						: 8'h00;
				OFS_CRYSTAL_ERROR_CALIBRATION:
					st_next.rdata = hi_sel ? {6'h00, st_reg.src}
						: st_reg.crystal_error_calibration;
				OFS_CNT:
					st_next.rdata = byte_of(st_reg.cnt, hi_sel);
				OFS_PER:
					st_next.rdata = byte_of(st_reg.per, hi_sel);
				OFS_CMP:
					st_next.rdata = byte_of(st_reg.cmp, hi_sel);
				OFS_PIT_CTRL:
					st_next.rdata = hi_sel ? {7'h00, st_reg.pit_busy}
						: st_reg.pit_ctrl;
				OFS_PIT_IEN:
					st_next.rdata = hi_sel ? {7'h00, st_reg.pit_flag}
						: {7'h00, st_reg.pit_ien};
				OFS_PIT_DBG & ~OFS_HIGH_BYTE:
					st_next.rdata = hi_sel ? {7'h00, st_reg.pit_dbg}
						: 8'h00;
				default:
					st_next.rdata = 8'h00;
			endcase
		end
	end

	// *****************************************************************
	// state register
	// *****************************************************************

	// synchronous reset to documented values
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_reg            <= '0;
			st_reg.ctrl       <= REG8_RESET;
			st_reg.crystal_error_calibration      <= REG8_RESET;
			st_reg.pit_ctrl   <= REG8_RESET;
			st_reg.pit_live   <= REG8_RESET;
			st_reg.cnt        <= CNT_RESET;
			st_reg.cnt_shadow <= CNT_RESET;
			st_reg.per        <= PER_RESET;
			st_reg.per_shadow <= PER_RESET;
			st_reg.cmp        <= CMP_RESET;
		end
		else
			st_reg <= st_next;
	end

	// outputs
	assign rdata = st_reg.rdata;
	assign irq   = (|(st_reg.flags & st_reg.int_en))
		| (st_reg.pit_flag & st_reg.pit_ien);

	// *****************************************************************
	// assertions
	// *****************************************************************

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	halt_freezes_count_a: assert property (
		debug_halted && !st_reg.dbg_run && !st_reg.cnt_busy
		|=> st_reg.cnt == $past(st_reg.cnt))
		else $error("count moved while halted");
	slow_correction_a: assert property (
		tick && cnt_run && corr_act && !corr_neg
		|=> st_reg.presc == $past(st_reg.presc))
		else $error("positive correction did not hold prescaler");
	fast_correction_a: assert property (
		tick && cnt_run && corr_act && corr_neg
		|=> st_reg.presc == 15'($past(st_reg.presc) + 15'h0002))
		else $error("negative correction did not double step");
	interval_reload_a: assert property (
		tick && cnt_run && st_reg.ppm_cnt == PPM_LAST
		|=> st_reg.corr_left == $past(st_reg.crystal_error_calibration[6:0]))
		else $error("correction budget not reloaded");
	high_byte_read_a: assert property (
		rd && addr == (OFS_CNT | OFS_HIGH_BYTE)
		|=> rdata == $past(st_reg.cnt[15:8])
		##1 (rdata == 8'h00 || $past(rd)))
		else $error("count high byte read wrong");
	count_sync_a: assert property (
		wr && base == OFS_CNT
		|=> st_reg.cnt_busy && st_reg.cnt_sync == 2'h0)
		else $error("count busy not raised on write");
	count_waits_a: assert property (
		st_reg.cnt_busy && !(tick && st_reg.cnt_sync == SYNC_LAST)
		|=> st_reg.cnt_busy)
		else $error("count busy dropped before second tick");
	count_lands_a: assert property (
		$fell(st_reg.cnt_busy) && !wr
		|-> st_reg.cnt == $past(st_reg.cnt_shadow))
		else $error("count write not applied");
	timer_busy_a: assert property (
		wr && addr == OFS_PIT_CTRL |=> st_reg.pit_busy)
		else $error("timer busy not raised");
	timer_off_a: assert property (
		(!st_reg.pit_live[0] || pit_code == PIT_CODE_RSVD)
		&& !st_reg.pit_flag |=> !st_reg.pit_flag)
		else $error("timer flag while disabled or reserved");
	timer_gate_a: assert property (
		!st_reg.pit_ien && (st_reg.flags & st_reg.int_en) == 2'h0
		|-> !irq)
		else $error("interrupt without enabled source");
	timer_clear_a: assert property (
		wr && addr == (OFS_PIT_IEN | OFS_HIGH_BYTE) && wdata[0]
		&& !pit_evt |=> !st_reg.pit_flag)
		else $error("timer flag not cleared by one");
	zero_keeps_a: assert property (
		st_reg.pit_flag && wr && addr == (OFS_PIT_IEN | OFS_HIGH_BYTE)
		&& !wdata[0] |=> st_reg.pit_flag)
		else $error("writing zero cleared timer flag");
	wrap_flag_a: assert property (
		cnt_evt && st_reg.cnt == st_reg.per && !st_reg.cnt_busy
		|=> st_reg.cnt == 16'h0000 && st_reg.flags[FLAG_OVF_BIT])
		else $error("overflow did not wrap and flag");

	timer_fires_c:  cover property ($rose(st_reg.pit_flag));
	overflow_c:     cover property ($rose(st_reg.flags[FLAG_OVF_BIT]));
	match_c:        cover property ($rose(st_reg.flags[FLAG_CMP_BIT]));
	count_synced_c: cover property ($fell(st_reg.cnt_busy));

endmodule

//--- verification/rtc_clock_sources.sv
// free-running rtc clock sources for the counter bench
`timescale 1ns/100ps
module rtc_clock_sources
#(
	// half periods in ns; fast stand-ins keep the run short
	parameter int INT_HALF = 80,
	parameter int XT_HALF  = 60,
	parameter int EXT_HALF = 50
)
(
	// source levels, unrelated to clk
	output logic osc_int,
	output logic osc_xtal,
	output logic osc_ext
);
	// ****************************
	// oscillators
	// ****************************
	// real sources never pause, so none stands still
	initial
	begin
		osc_int = 1'b0;
		forever #(INT_HALF) osc_int = ~osc_int;
	end
	// crystal input, own phase
	initial
	begin
		osc_xtal = 1'b0;
		#3;
		forever #(XT_HALF) osc_xtal = ~osc_xtal;
	end
	// external pin, own phase
	initial
	begin
		osc_ext = 1'b0;
		#7;
		forever #(EXT_HALF) osc_ext = ~osc_ext;
	end
endmodule

//--- verification/test_rtc_counter_and_periodic_timer.sv
// self-checking bench for the rtc counter and periodic timer
`timescale 1ns/100ps
module test_rtc_counter_and_periodic_timer;
	import rtc_pkg::*;
	// one expected read
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] v;
	} note_t;
	// ****************************
	// signals and tables
	// ****************************
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  rdata;
	logic        osc_int;
	logic        osc_xtal;
	logic        osc_ext;
	logic        debug_halted = 1'b0;
	logic        irq;
	logic        rd_q = 1'b0;  // read answer due
	logic [7:0]  seed = 8'h33; // lfsr state
	note_t       notes[$];     // pending reads
	note_t       got;
	int          mismatches = 0;
	int          checked = 0;
	int          cyc = 0;      // cycle count, also timeout
	int          t[3];         // irq rise times
	// address, reset value; 0x0e is unmapped
	logic [15:0] rst_tab[15] = '{16'h0500, 16'h0600, 16'h0700,
		16'h0800, 16'h0900, 16'h0aff, 16'h0bff, 16'h0c00, 16'h0d00,
		16'h0e00, 16'h1000, 16'h1100, 16'h1200, 16'h1300, 16'h1500};
	logic [7:0]  rw_tab[3] = '{OFS_CRYSTAL_ERROR_CALIBRATION, OFS_CMP, OFS_CMP + 8'h01};
	// source, code, expected clk cycles between interrupts
	int          tab[6][3] = '{'{0, 1, 64}, '{1, 1, 2048}, '{2, 1, 48},
		'{3, 1, 40}, '{0, 2, 128}, '{0, 3, 256}};
	// disabled, code off, reserved code
	logic [7:0]  off_tab[3] = '{8'h08, 8'h01, 8'h79};

	always #5 clk = ~clk;

	rtc_clock_sources sources (
		.osc_int(osc_int),
		.osc_xtal(osc_xtal),
		.osc_ext(osc_ext)
	);

	rtc_periodic_timer dut (
		.clk(clk),
		.srst(srst),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.internal_slow_oscillator(osc_int),
		.crystal_input_pin(osc_xtal),
		.external_clock_pin(osc_ext),
		.debug_halted(debug_halted),
		.irq(irq)
	);

	// ****************************
	// helpers
	// ****************************
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic check(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (e !== g)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic stop_test();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one-cycle write; trailing idle cycle avoids double assignment
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// one-cycle read; the monitor compares the answer
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		notes.push_back(note_t'{a, e});
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask

	// bounded wait for an irq level, sampled mid-cycle
	task automatic wait_irq(input logic lvl, input int lim);
		int n;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (irq !== lvl && n < lim);
		check("irq", {15'h0, lvl}, {15'h0, irq});
	endtask

	// irq must show lvl after n cycles
	task automatic hold(input logic lvl, input int n);
		repeat (n) @(negedge clk);
		check("irq", {15'h0, lvl}, {15'h0, irq});
	endtask

	// third rise is timed from the second; the first may be stale
	task automatic interval(input logic [1:0] s, input logic [3:0] c,
		input int e);
		wr_reg(OFS_SRC, {6'h0, s});
		wr_reg(OFS_PIT_CTRL, {1'b0, c, 3'h1});
		for (int i = 0; i < 3; i++)
		begin
			wait_irq(1'b1, 9000);
			t[i] = cyc;
			wr_reg(OFS_PIT_FLAG, 8'h01);
		end
		check("pit interval", 16'(e), 16'(t[2] - t[1]));
	endtask

	// ****************************
	// monitor and timeout
	// ****************************
	always @(posedge clk)
	begin
		rd_q <= rd;
		cyc <= cyc + 1;
		// answer stands only in the cycle after the strobe
		if (rd_q)
		begin
			got = notes.pop_front();
			check($sformatf("reg %h", got.a), {8'h0, got.v}, {8'h0, rdata});
		end
		if (cyc == 40000)
		begin
			mismatches++;
			stop_test();
		end
	end

	// ****************************
	// main sequence
	// ****************************
	initial
	begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		foreach (rst_tab[i])
			rd_reg(rst_tab[i][15:8], rst_tab[i][7:0]);
		foreach (rw_tab[i])
		begin
			seed = lfsr(seed);
			wr_reg(rw_tab[i], seed);
			rd_reg(rw_tab[i], seed);
		end
		// count and period land after synchronisation
		wr_reg(OFS_CNT, 8'h10);
		wr_reg(OFS_CNT + OFS_HIGH_BYTE, 8'h00);
		wr_reg(OFS_PER, 8'h40);
		wr_reg(OFS_PER + OFS_HIGH_BYTE, 8'h00);
		rd_reg(OFS_STATUS, 8'h06);
		repeat (80) @(posedge clk);
		rd_reg(OFS_STATUS, 8'h00);
		rd_reg(OFS_CNT, 8'h10);
		wr_reg(OFS_CMP, 8'h12);
		wr_reg(OFS_CMP + OFS_HIGH_BYTE, 8'h00);
		wr_reg(OFS_INT_EN, 8'h03);
		// halted with debug-run clear: no counting
		@(posedge clk);
		debug_halted <= 1'b1;
		// correction stays off, so no divide floor is needed
		wr_reg(OFS_CTRL, 8'h01);
		hold(1'b0, 400);
		rd_reg(OFS_CNT, 8'h10);
		@(posedge clk);
		debug_halted <= 1'b0;
		wait_irq(1'b1, 200);
		rd_reg(OFS_INT_FLAG, 8'h02);
		wr_reg(OFS_INT_FLAG, 8'h00);
		rd_reg(OFS_INT_FLAG, 8'h02);
		wr_reg(OFS_INT_FLAG, 8'h02);
		// halted with debug-run set: overflow still comes
		wr_reg(OFS_DBG, 8'h01);
		@(posedge clk);
		debug_halted <= 1'b1;
		wait_irq(1'b1, 2000);
		rd_reg(OFS_INT_FLAG, 8'h01);
		wr_reg(OFS_INT_FLAG, 8'h01);
		wr_reg(OFS_CTRL, 8'h00);
		hold(1'b0, 4);
		@(posedge clk);
		debug_halted <= 1'b0;
		// periodic timer
		wr_reg(OFS_PIT_IEN, 8'h01);
		wr_reg(OFS_PIT_CTRL, 8'h09);
		rd_reg(OFS_PIT_STAT, 8'h01);
		foreach (tab[i])
			interval(2'(tab[i][0]), 4'(tab[i][1]), tab[i][2]);
		wr_reg(OFS_PIT_IEN, 8'h00);
		hold(1'b0, 300);
		rd_reg(OFS_PIT_FLAG, 8'h01);
		wr_reg(OFS_PIT_FLAG, 8'h00);
		rd_reg(OFS_PIT_FLAG, 8'h01);
		wr_reg(OFS_PIT_IEN, 8'h01);
		hold(1'b1, 1);
		foreach (off_tab[i])
		begin
			wr_reg(OFS_PIT_CTRL, off_tab[i]);
			repeat (60) @(posedge clk);
			wr_reg(OFS_PIT_FLAG, 8'h01);
			hold(1'b0, 600);
		end
		stop_test();
	end
endmodule
